// ---- design/otc_output_trigger_control.sv ----
// Output control: RF enable, blanking, reference direction, filter centring, trigger pulses.
//
// The APB register port and the register offsets were chosen for this implementation.
module otc_output_trigger_control
    import otc_pkg::*;
#(
    parameter int STEPS    = 16,
    parameter int HZ_STEP  = 1000
) (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic               ce,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               change_busy,
    input  wire logic               ref_src_internal,
    input  wire logic [15:0]        filt_level,
    output logic                    rf_on,
    output logic                    reference_clock_port_dir,
    output logic      [DAC_W-1:0]   tuned_bandpass_filter_dac,
    output logic      [1:0]         ecl_trig,
    output logic      [7:0]         ttl_trig
);
    typedef enum logic [1:0] {FS_IDLE, FS_SWEEP, FS_DONE} otc_fsm_type;

    // All state but the line_high width counters lives in one record; one comb process computes its successor.
    typedef struct packed {
        logic [4:0]         ctrl;
        logic [1:0]         ecl_en;
        logic [7:0]         ttl_en;
        logic [1:0]         ecl_out;
        logic [7:0]         ttl_out;
        logic [CNT_W-1:0]   ecl_cnt0;
        logic [CNT_W-1:0]   ecl_cnt1;
        logic [7:0][CNT_W-1:0] ttl_cnt;
        logic               conflict;
        logic               busy_d;
        logic [DAC_W-1:0]   dac;
        logic [DAC_W-1:0]   dac_orig;
        logic [DAC_W-1:0]   dac_best;
        logic [15:0]        best_lvl;
        logic [7:0]         step_cnt;
        logic [DAC_W-1:0]   step_size;
        otc_fsm_type        fsm;
        logic [SHIFT_W-1:0] shift;
        logic [31:0]        rdata;
        logic               rd_ok;
    } otc_state_type;

    otc_state_type st;
    otc_state_type next_st;

    logic       wr;
    logic       rd;
    logic [9:0] fire;
    logic       change_done;

    assign wr          = psel && penable && pwrite;
    assign rd          = psel && penable && !pwrite;
    // Writes finish at once; a read waits one cycle so prdata leaves a flip-flop.
    assign pready      = !rd || st.rd_ok;
    assign pslverr     = 1'b0;
    assign change_done = st.busy_d && !change_busy;

    always_comb begin
        next_st = st;
        next_st.busy_d = change_busy;
        fire = '0;
        // Commands are one-way broadcasts on any set of lines; nothing waits on a reply from listeners.
        if (wr && paddr == ADDR_TRIG_CMD) begin
            fire = pwdata[9:0];
        end
        if (st.ctrl[CTRL_AUTO_TRIG] && change_done) begin
            fire = 10'h3FF;
        end
        for (int i = 0; i < 2; i++) begin
            if (fire[i] && st.ecl_en[i]) begin
                next_st.ecl_out[i] = 1'b1;
            end
        end
        // A pulse already running is not restarted by a second request.
        if (next_st.ecl_out[0] && !st.ecl_out[0]) next_st.ecl_cnt0 = CNT_W'(PULSE_CYC - 1);
        else if (st.ecl_cnt0 != '0) next_st.ecl_cnt0 = st.ecl_cnt0 - 1'b1;
        else next_st.ecl_out[0] = 1'b0;
        if (next_st.ecl_out[1] && !st.ecl_out[1]) next_st.ecl_cnt1 = CNT_W'(PULSE_CYC - 1);
        else if (st.ecl_cnt1 != '0) next_st.ecl_cnt1 = st.ecl_cnt1 - 1'b1;
        else next_st.ecl_out[1] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (fire[i+2] && st.ttl_en[i] && !st.ttl_out[i]) begin
                next_st.ttl_out[i] = 1'b1;
                next_st.ttl_cnt[i] = CNT_W'(PULSE_CYC - 1);
            end else if (st.ttl_cnt[i] != '0) begin
                next_st.ttl_cnt[i] = st.ttl_cnt[i] - 1'b1;
            end else begin
                next_st.ttl_out[i] = 1'b0;
            end
        end
        if (wr && paddr == ADDR_CTRL) begin
            next_st.ctrl = pwdata[4:0] & 5'h0F;
        end
        if (wr && paddr == ADDR_TRIG_EN) begin
            next_st.ecl_en = pwdata[1:0];
            next_st.ttl_en = pwdata[9:2];
        end
        if (wr && paddr == ADDR_CTRL && pwdata[CTRL_ERR_CLR]) begin
            next_st.conflict = 1'b0;
        end
        // The flag is sticky; a conflict seen in the same cycle as a clear wins.
        if ((next_st.ctrl[CTRL_REF_OUT] || st.ctrl[CTRL_REF_OUT])
                && !ref_src_internal) begin
            next_st.conflict = 1'b1;
        end
        if (wr && paddr == ADDR_FILT_STEP) begin
            next_st.step_size = pwdata[DAC_W-1:0];
        end
        unique case (st.fsm)
            FS_IDLE: begin
                if (wr && paddr == ADDR_FILT_DAC) begin
                    next_st.dac = pwdata[DAC_W-1:0];
                end
                if (wr && paddr == ADDR_FILT_CMD && pwdata[0]) begin
                    next_st.dac_orig = st.dac;
                    next_st.dac_best = st.dac;
                    next_st.best_lvl = '0;
                    next_st.step_cnt = '0;
                    next_st.dac = st.dac - DAC_W'(STEPS / 2) * st.step_size;
                    next_st.fsm = FS_SWEEP;
                end
            end
            FS_SWEEP: begin
                if (filt_level > st.best_lvl) begin
                    next_st.best_lvl = filt_level;
                    next_st.dac_best = st.dac;
                end
                next_st.dac = st.dac + st.step_size;
                next_st.step_cnt = st.step_cnt + 1'b1;
                if (st.step_cnt == 8'(STEPS - 1)) begin
                    next_st.fsm = FS_DONE;
                end
            end
            FS_DONE: begin
                next_st.dac = st.dac_best;
                // Signed shift: a lower centre gives a negative value.
                next_st.shift = SHIFT_W'(($signed({1'b0, st.dac_best}) -
                    $signed({1'b0, st.dac_orig})) * HZ_STEP);
                next_st.fsm = FS_IDLE;
            end
        endcase
        // Read data is caught on the first access edge and stands while pready is high.
        next_st.rdata = st.rdata;
        next_st.rd_ok = rd && !st.rd_ok;
        if (rd && !st.rd_ok) begin
            unique case (paddr)
                ADDR_CTRL:       next_st.rdata = 32'(st.ctrl[3:0]);
                ADDR_TRIG_EN:    next_st.rdata = {22'h0, st.ttl_en, st.ecl_en};
                ADDR_STATUS:     next_st.rdata = {29'h0, st.fsm != FS_IDLE, st.conflict,
                                                  change_busy};
                ADDR_FILT_DAC:   next_st.rdata = 32'(st.dac);
                ADDR_FILT_SHIFT: next_st.rdata = st.shift;
                ADDR_FILT_STEP:  next_st.rdata = 32'(st.step_size);
                default:         next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st          <= '0;
            st.ctrl     <= CTRL_RESET;
            st.step_size <= 12'h001;
            st.fsm      <= FS_IDLE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Read data leaves the state register, never the bus decode directly.
    assign prdata = st.rdata;

    assign rf_on = st.ctrl[CTRL_RF_EN] && !(st.ctrl[CTRL_BLANK] && change_busy);
    assign reference_clock_port_dir  = st.ctrl[CTRL_REF_OUT];
    assign tuned_bandpass_filter_dac = st.dac;
    assign ecl_trig = st.ecl_out;
    assign ttl_trig = st.ttl_out;

    // Each line's high time is counted in enabled cycles, so a pause of ce does not trip it.
    logic [9:0]       line_out;
    logic [CNT_W-1:0] line_high [10];

    assign line_out = {ttl_trig, ecl_trig};

    for (genvar g = 0; g < 10; g++) begin : g_width
        always_ff @(posedge mclk) begin
            if (srst) begin
                line_high[g] <= '0;
            end else if (ce) begin
                line_high[g] <= line_out[g] ? line_high[g] + 1'b1 : '0;
            end
        end

        line_width_a: assert property (@(posedge mclk) disable iff (srst || !ce)
            $fell(line_out[g]) |-> line_high[g] == CNT_W'(PULSE_CYC))
            else $error("trigger pulse width wrong");
    end

    // Blanking, enable gating of the RF path and the reference port direction.
    rf_blank_a: assert property (@(posedge mclk) disable iff (srst)
        (st.ctrl[CTRL_BLANK] && change_busy) |-> !rf_on)
        else $error("rf not blanked during change");
    rf_keep_a: assert property (@(posedge mclk) disable iff (srst)
        (!st.ctrl[CTRL_BLANK] && st.ctrl[CTRL_RF_EN] && change_busy) |-> rf_on)
        else $error("rf dropped during change");
    rf_gate_a: assert property (@(posedge mclk) disable iff (srst)
        rf_on |-> st.ctrl[CTRL_RF_EN])
        else $error("rf without enable");
    ref_dir_a: assert property (@(posedge mclk) disable iff (srst)
        reference_clock_port_dir == st.ctrl[CTRL_REF_OUT])
        else $error("reference port direction wrong");

    // Triggers: width, enable gating and the two launch sources.
    ttl_width_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        $rose(ttl_trig[0]) |-> ttl_trig[0] [*8] ##1 ttl_trig[0])
        else $error("ttl pulse short");
    ttl_gate_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(ttl_trig[1]) |-> $past(st.ttl_en[1]))
        else $error("ttl disabled line fired");
    ttl_ignore_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (ce && !st.ttl_en[0] && !st.ttl_out[0]) |=> !ttl_trig[0])
        else $error("ttl pulse on disabled line");
    ecl_gate_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(ecl_trig[0]) |-> $past(st.ecl_en[0]))
        else $error("ecl disabled line fired");
    ecl_fire_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (ce && wr && paddr == ADDR_TRIG_CMD && pwdata[1] && st.ecl_en[1] && !st.ecl_out[1])
        |=> ecl_trig[1])
        else $error("ecl command gave no pulse");
    auto_fire_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (ce && st.ctrl[CTRL_AUTO_TRIG] && change_done && st.ttl_en[0] && !st.ttl_out[0])
        |=> ttl_trig[0])
        else $error("no pulse after change");

    // Conflict flag, reset state, bus timing and status reads.
    conflict_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (st.ctrl[CTRL_REF_OUT] && !ref_src_internal) |=> st.conflict)
        else $error("no conflict flagged");
    reset_off_a: assert property (@(posedge mclk)
        ($past(srst) && !srst) |-> (ttl_trig == '0 && ecl_trig == '0 && !rf_on
            && !reference_clock_port_dir && st.ttl_en == '0 && st.ecl_en == '0))
        else $error("outputs not off after reset");
    wr_ready_a: assert property (@(posedge mclk) disable iff (srst)
        (psel && penable && pwrite) |-> pready)
        else $error("write not answered at once");
    rd_wait_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (ce && rd && !st.rd_ok) |=> (pready && st.rd_ok))
        else $error("read wait state wrong");
    en_read_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (ce && rd && !st.rd_ok && paddr == ADDR_TRIG_EN) |=>
        (prdata[9:0] == $past({st.ttl_en, st.ecl_en})))
        else $error("enable status wrong");
    blank_read_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (ce && rd && !st.rd_ok && paddr == ADDR_CTRL) |=>
        (prdata[CTRL_BLANK] == $past(st.ctrl[CTRL_BLANK])))
        else $error("blanking status wrong");

    // Filter centring ends on the best word and reports the shift with its sign.
    centre_dac_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (ce && st.fsm == FS_DONE) |=> (tuned_bandpass_filter_dac == $past(st.dac_best)))
        else $error("filter not left on peak");
    shift_sign_a: assert property (@(posedge mclk) disable iff (srst || !ce)
        (ce && st.fsm == FS_DONE && st.dac_best < st.dac_orig) |=> st.shift[SHIFT_W-1])
        else $error("downward shift not negative");

    // Main scenarios worth seeing.
    ttl_fire_c: cover property (@(posedge mclk) $rose(ttl_trig[7]));
    ecl_fire_c: cover property (@(posedge mclk) $rose(ecl_trig[1]));
    centre_c: cover property (@(posedge mclk) st.fsm == FS_DONE);
    auto_trig_c: cover property (@(posedge mclk) st.ctrl[CTRL_AUTO_TRIG] && change_done);
endmodule // otc_output_trigger_control

// ---- design/otc_pkg.sv ----
// Package with register map, field positions and timing counts of the output control block.
package otc_pkg;
    localparam int          CLK_MHZ        = 200;
    localparam int          PULSE_NS       = 400;
    localparam int          PULSE_CYC      = PULSE_NS * CLK_MHZ / 1000;
    localparam int          CNT_W          = 8;
    localparam int          DAC_W          = 12;
    localparam int          SHIFT_W        = 32;
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_TRIG_EN   = 12'h004;
    localparam logic [11:0] ADDR_TRIG_CMD  = 12'h008;
    localparam logic [11:0] ADDR_STATUS    = 12'h00C;
    localparam logic [11:0] ADDR_FILT_DAC  = 12'h010;
    localparam logic [11:0] ADDR_FILT_CMD  = 12'h014;
    localparam logic [11:0] ADDR_FILT_SHIFT = 12'h018;
    localparam logic [11:0] ADDR_FILT_STEP = 12'h01C;
    localparam int          CTRL_RF_EN     = 0;
    localparam int          CTRL_BLANK     = 1;
    localparam int          CTRL_REF_OUT   = 2;
    localparam int          CTRL_AUTO_TRIG = 3;
    localparam int          CTRL_ERR_CLR   = 4;
    localparam int          ST_CHANGING    = 0;
    localparam int          ST_CONFLICT    = 1;
    localparam int          ST_FILT_BUSY   = 2;
    localparam logic [4:0]  CTRL_RESET     = 5'h02;
endpackage

// ---- test/otc_trig_listener.sv ----
// Backplane trigger listener that measures each pulse it sees on the ten lines.
module otc_trig_listener (
    input  wire logic            mclk,
    input  wire logic [9:0]      trig,
    output logic      [9:0]      done,
    output logic      [9:0][7:0] width
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0][7:0] cnt  = '0;
    logic [9:0]      prev = '0;
    // Listeners only watch the lines and never answer the sender.
    always_ff @(posedge mclk) begin
        prev <= trig;
        for (int i = 0; i < 10; i++) begin
            cnt[i]   <= (trig[i] === 1'b1) ? cnt[i] + 8'h01 : 8'h00;
            done[i]  <= prev[i] & ~trig[i];
            width[i] <= cnt[i];
        end
    end
endmodule // otc_trig_listener

// ---- test/otc_output_trigger_control_tb_top.sv ----
// Testbench of the output control block with its trigger listener.
module otc_output_trigger_control_tb_top;
    import otc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, busy = 0, rsi = 1, ce = 1;
    logic [11:0] paddr = '0, dac, tgt = '0;
    logic [31:0] pwdata = '0, prdata, v;
    logic [15:0] lvl;
    logic pready, pslverr, rf_on, rdir;
    logic [1:0] ecl;
    logic [7:0] ttl;
    logic [9:0] done;
    logic [9:0][7:0] wid;
    logic [31:0] rq[$], pq[$];
    string nq[$];
    int n_mismatch = 0, n_checks = 0, k;
    initial forever #2.5 mclk = ~mclk;
    // Detector level peaks only when the filter word hits the target.
    assign lvl = (dac == tgt) ? 16'hFFFF : 16'h0010;
    otc_output_trigger_control i_dut (.mclk(mclk), .srst(srst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .change_busy(busy), .ref_src_internal(rsi),
        .filt_level(lvl), .rf_on(rf_on), .reference_clock_port_dir(rdir),
        .tuned_bandpass_filter_dac(dac), .ecl_trig(ecl), .ttl_trig(ttl));
    otc_trig_listener i_lis (.mclk(mclk), .trig({ttl, ecl}), .done(done), .width(wid));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 64) begin
            n++;
            @(posedge mclk);
        end
        if (n >= 64) n_mismatch++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        nq.push_back(nm);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Read data and measured pulses are matched against the oldest notes.
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            check("pslverr", {31'h0, pslverr}, 32'h0);
            if (!pwrite && rq.size() > 0) check(nq.pop_front(), prdata, rq.pop_front());
        end
        for (int i = 0; i < 10; i++)
            if (done[i] === 1'b1) begin
                if (pq.size() == 0) check("stray pulse", 32'(i), 32'hFFFF_FFFF);
                else check("pulse", 32'(i * 256 + wid[i]), pq.pop_front());
            end
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        final_report();
    end
    initial begin
        void'($urandom(63348));
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        #1 check("outs", {8'h00, rf_on, rdir, dac, ecl, ttl}, 32'h0);
        rd("ctrl", ADDR_CTRL, 32'h2);
        rd("trig_en", ADDR_TRIG_EN, 32'h0);
        apb(1'b1, ADDR_TRIG_CMD, 32'h3FF);
        apb(1'b1, ADDR_CTRL, 32'h3);
        #1 check("rf_on", {31'h0, rf_on}, 32'h1);
        @(posedge mclk);
        busy <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 check("rf_on", {31'h0, rf_on}, 32'h0);
        @(posedge mclk);
        busy <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h1);
        rd("ctrl", ADDR_CTRL, 32'h1);
        busy <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 check("rf_on", {31'h0, rf_on}, 32'h1);
        @(posedge mclk);
        busy <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, ADDR_TRIG_EN, 32'h1 << i);
            pq.push_back(32'(i * 256 + PULSE_CYC + (i == 0 ? 3 : 0)));
            apb(1'b1, ADDR_TRIG_CMD, 32'h3FF);
            rd("trig_en", ADDR_TRIG_EN, 32'h1 << i);
            if (i == 0) begin
                ce <= 1'b0;
                repeat (3) @(posedge mclk);
                ce <= 1'b1;
            end
            repeat (PULSE_CYC + 5) @(posedge mclk);
        end
        k = $urandom_range(9);
        apb(1'b1, ADDR_TRIG_EN, 32'h1 << k);
        apb(1'b1, ADDR_CTRL, 32'hA);
        busy <= 1'b1;
        repeat (4) @(posedge mclk);
        pq.push_back(32'(k * 256 + PULSE_CYC));
        busy <= 1'b0;
        repeat (PULSE_CYC + 8) @(posedge mclk);
        rsi <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h6);
        #1 check("ref_dir", {31'h0, rdir}, 32'h1);
        rd("status", ADDR_STATUS, 32'h2);
        rsi <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h12);
        #1 check("ref_dir", {31'h0, rdir}, 32'h0);
        rd("status", ADDR_STATUS, 32'h0);
        v = $urandom & 32'hFFF;
        apb(1'b1, ADDR_FILT_DAC, v);
        #1 check("dac", {20'h0, dac}, v);
        rd("dac", ADDR_FILT_DAC, v);
        for (int j = 0; j < 2; j++) begin
            k = int'($urandom_range(7)) - 8 * (1 - j);
            v = 32'h10 + $urandom_range(4000);
            tgt <= 12'(int'(v) + k);
            apb(1'b1, ADDR_FILT_DAC, v);
            apb(1'b1, ADDR_FILT_CMD, 32'h1);
            repeat (24) @(posedge mclk);
            check("dac pin", {20'h0, dac}, {20'h0, tgt});
            rd("shift", ADDR_FILT_SHIFT, 32'(k * 1000));
            rd("centre", ADDR_FILT_DAC, {20'h0, tgt});
        end
        rd("unmapped", 12'h020, 32'h0);
        repeat (10) @(posedge mclk);
        check("pending", 32'(pq.size() + rq.size()), 32'h0);
        final_report();
    end
endmodule // otc_output_trigger_control_tb_top
